//--- port_devctl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module port_devctl_asserts (
  input wire logic        clk,                 // clock
  input wire logic        nrst,                // reset
  input wire logic        por_nrst,            // por
  input wire logic        large_payload_strap, // strap
  input wire logic [7:0]  reg_addr,            // addr
  input wire logic [31:0] reg_wdata,           // wdata
  input wire logic        reg_wr,              // write
  input wire logic        reg_rd,              // read
  input wire logic [31:0] reg_rdata,           // rdata
  input wire logic        corr_report_en,      // bit 0
  input wire logic        nonfatal_report_en,  // bit 1
  input wire logic        fatal_report_en,     // bit 2
  input wire logic        unsup_report_en,     // bit 3
  input wire logic [2:0]  max_payload,         // 7:5
  input wire logic [2:0]  payload_cap,         // cap
  input wire logic        aux_power_en         // bit 10
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // accesses that hit the control word
  sequence wr_hit; reg_wr && reg_addr == 8'hC8; endsequence
  sequence rd_hit; reg_rd && reg_addr == 8'hC8; endsequence
  chk_err_enables: assert property (wr_hit |=>
    {unsup_report_en, fatal_report_en, nonfatal_report_en, corr_report_en} == $past(reg_wdata[3:0]))
    else $error("enable bits not loaded");
  chk_payload_clamp: assert property (wr_hit |=> max_payload ==
    ($past(reg_wdata[7:5]) > $past(payload_cap) ? $past(payload_cap) : $past(reg_wdata[7:5])))
    else $error("payload not clamped");
  chk_fixed_zero: assert property (rd_hit |=> (reg_rdata & 32'hFFFF_FB10) == 32'h0)
    else $error("fixed field not zero");
  chk_read_payload: assert property (rd_hit |=> reg_rdata[7:5] == $past(max_payload))
    else $error("payload read wrong");
  chk_read_aux: assert property (rd_hit |=> reg_rdata[10] == $past(aux_power_en))
    else $error("aux read wrong");
  // outside writes to the word, only power-on reset may clear the sticky bit
  chk_aux_sticky: assert property (@(posedge clk) disable iff (!por_nrst)
    !(reg_wr && reg_addr == 8'hC8) |=> $stable(aux_power_en)) else $error("aux bit lost");
  chk_cap_large: assert property (large_payload_strap [*8] |-> payload_cap == 3'h2)
    else $error("cap not large");
  chk_cap_small: assert property (!large_payload_strap [*8] |-> payload_cap == 3'h1)
    else $error("cap not small");
endmodule
`default_nettype wire

//--- port_devctl_pkg.sv
`default_nettype none
package port_devctl_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0]  PORT_DEVICE_CONTROL_OFS = 8'hC8;

  // field positions inside port_device_control
  localparam int unsigned CORR_EN_BIT    = 0;
  localparam int unsigned NONFATAL_EN_BIT = 1;
  localparam int unsigned FATAL_EN_BIT   = 2;
  localparam int unsigned UNSUP_EN_BIT   = 3;
  localparam int unsigned RELAX_ORD_BIT  = 4;
  localparam int unsigned PAYLOAD_LSB    = 5;
  localparam int unsigned PAYLOAD_MSB    = 7;
  localparam int unsigned EXT_TAG_BIT    = 8;
  localparam int unsigned PHANTOM_BIT    = 9;
  localparam int unsigned AUX_PWR_BIT    = 10;
  localparam int unsigned NO_SNOOP_BIT   = 11;
  localparam int unsigned RDREQ_LSB      = 12;
  localparam int unsigned RDREQ_MSB      = 14;
  localparam int unsigned RSVD_BIT       = 15;

  // payload size codes
  localparam logic [2:0] PAYLOAD_RESET     = 3'h0;
  localparam logic [2:0] PAYLOAD_CAP_SMALL = 3'h1;
  localparam logic [2:0] PAYLOAD_CAP_LARGE = 3'h2;
  localparam logic [2:0] RDREQ_FIXED       = 3'h0;
endpackage
`default_nettype wire

//--- port_device_control.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module port_device_control (
  input  wire logic        clk,                 // 20 MHz core clock
  input  wire logic        nrst,                // conventional reset, async, active low
  input  wire logic        por_nrst,            // power-on reset, async, active low
  input  wire logic        large_payload_strap, // strap pin, asynchronous
  input  wire logic [7:0]  reg_addr,            // register byte address
  input  wire logic [31:0] reg_wdata,           // write data
  input  wire logic        reg_wr,              // write strobe
  input  wire logic        reg_rd,              // read strobe
  output logic      [31:0] reg_rdata,           // read data, cycle after strobe
  output logic             corr_report_en,      // correctable error reporting
  output logic             nonfatal_report_en,  // non-fatal error reporting
  output logic             fatal_report_en,     // fatal error reporting
  output logic             unsup_report_en,     // unsupported request reporting
  output logic      [2:0]  max_payload,         // programmed payload size code
  output logic      [2:0]  payload_cap,         // supported payload capability
  output logic             aux_power_en         // sticky aux power enable
);

  // strap synchroniser stages; the first stage feeds only the second
  logic        strap_s1_r;   // first capture of the strap pin
  logic        strap_s2_r;   // second stage, first trusted level
  logic        strap_s3_r;   // third stage, compared with the second
  logic        strap_r;      // filtered strap level
  logic        strap_nxt;    // next filtered strap level
  logic [2:0]  cap_nxt;      // next supported payload code

  // bus decode
  logic        sel_wr;       // write hits the control word
  logic        sel_rd;       // read hits the control word
  logic [2:0]  wr_code;      // payload code as written
  logic        clamp_hit;    // written code above capability

  // writable fields
  logic [3:0]  err_en_r;     // four reporting enables
  logic [3:0]  err_en_nxt;   // next reporting enables
  logic [2:0]  payload_r;    // stored payload code
  logic [2:0]  payload_nxt;  // next payload code

  // sticky field
  logic        aux_r;        // sticky aux power enable
  logic        aux_nxt;      // next aux power enable

  // read path
  logic [31:0] rdata_nxt;    // next read data
  logic [15:0] ctl_view;     // control word as software sees it

  // address decode
  // only the full byte address selects the word; there are no byte
  // enables, so a hit always carries all sixteen control bits at once
  assign sel_wr = reg_wr && (reg_addr == port_devctl_pkg::PORT_DEVICE_CONTROL_OFS);
  assign sel_rd = reg_rd && (reg_addr == port_devctl_pkg::PORT_DEVICE_CONTROL_OFS);

  // payload code lifted out of the write data
  // the slice is fixed by the package, so it cannot drift from the view
  assign wr_code = reg_wdata[port_devctl_pkg::PAYLOAD_MSB:port_devctl_pkg::PAYLOAD_LSB];

  // clamp compare against the registered capability
  // the registered copy keeps the compare off the synchroniser path,
  // at the cost of one more edge before a strap change takes effect
  assign clamp_hit = (wr_code > payload_cap);

  // strap filter and capability select
  // strap is taken only once two later stages agree, so a glitch is not seen
  // a strap that toggles every cycle simply keeps the last agreed level
  always_comb begin
    strap_nxt = strap_r;
    if (strap_s2_r == strap_s3_r) begin
      strap_nxt = strap_s3_r;
    end

    if (strap_nxt) begin
      cap_nxt = port_devctl_pkg::PAYLOAD_CAP_LARGE;
    end else begin
      cap_nxt = port_devctl_pkg::PAYLOAD_CAP_SMALL;
    end
  end

  // strap stages and capability register
  // the capability resets to the small code, so a clamp during the
  // first few cycles after reset errs on the safe side

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_s1_r  <= 1'b0;
      strap_s2_r  <= 1'b0;
      strap_s3_r  <= 1'b0;
      strap_r     <= 1'b0;
      payload_cap <= port_devctl_pkg::PAYLOAD_CAP_SMALL;
    end else begin
      strap_s1_r  <= large_payload_strap;
      strap_s2_r  <= strap_s1_r;
      strap_s3_r  <= strap_s2_r;
      strap_r     <= strap_nxt;
      payload_cap <= cap_nxt;
    end
  end


  // next values of the writable fields
  // every write to the word reloads all four enables and the payload
  // code; there is no partial write, matching the bus without byte lanes
  always_comb begin
    err_en_nxt  = err_en_r;
    payload_nxt = payload_r;

    if (sel_wr) begin
      err_en_nxt[0] = reg_wdata[port_devctl_pkg::CORR_EN_BIT];
      err_en_nxt[1] = reg_wdata[port_devctl_pkg::NONFATAL_EN_BIT];
      err_en_nxt[2] = reg_wdata[port_devctl_pkg::FATAL_EN_BIT];
      err_en_nxt[3] = reg_wdata[port_devctl_pkg::UNSUP_EN_BIT];
      payload_nxt = wr_code;

      // clamp to capability
      // software that asks for more than the port supports gets the
      // largest legal code instead of an unusable one
      if (clamp_hit) begin
        payload_nxt = payload_cap;
      end
    end
  end

  // conventional reset clears the ordinary fields
  // both resets are asynchronous; the ordinary fields follow only the
  // conventional one, which the power-on reset is expected to accompany
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_en_r  <= 4'h0;
      payload_r <= port_devctl_pkg::PAYLOAD_RESET;
    end else begin
      err_en_r  <= err_en_nxt;
      payload_r <= payload_nxt;
    end
  end


  // sticky bit: a conventional reset must not disturb it
  // a write during a conventional reset is still taken here, since the
  // bit lives only in the power-on reset domain
  always_comb begin
    aux_nxt = aux_r;

    if (sel_wr) begin
      aux_nxt = reg_wdata[port_devctl_pkg::AUX_PWR_BIT];
    end
  end


  // sticky aux enable
  // of the two resets, only power-on reset clears it; that reset must be held low with
  // the conventional one at power-up, or the bit starts unknown
  always_ff @(posedge clk or negedge por_nrst) begin
    if (!por_nrst) begin
      aux_r <= 1'b0;
    end else begin
      aux_r <= aux_nxt;
    end
  end


  // read view; hardwired zero fields are never stored, so writes cannot reach them
  // keeping them as constants rather than flops saves area and removes
  // any chance of a stray write surviving into a requester field
  always_comb begin
    ctl_view = 16'h0000;

    // reporting enables
    ctl_view[port_devctl_pkg::CORR_EN_BIT]     = err_en_r[0];
    ctl_view[port_devctl_pkg::NONFATAL_EN_BIT] = err_en_r[1];
    ctl_view[port_devctl_pkg::FATAL_EN_BIT]    = err_en_r[2];
    ctl_view[port_devctl_pkg::UNSUP_EN_BIT]    = err_en_r[3];
    ctl_view[port_devctl_pkg::RELAX_ORD_BIT] = 1'b0;

    // programmed payload size
    ctl_view[port_devctl_pkg::PAYLOAD_MSB:port_devctl_pkg::PAYLOAD_LSB] = payload_r;

    ctl_view[port_devctl_pkg::EXT_TAG_BIT] = 1'b0;
    ctl_view[port_devctl_pkg::PHANTOM_BIT] = 1'b0;

    // sticky aux power enable
    ctl_view[port_devctl_pkg::AUX_PWR_BIT] = aux_r;

    ctl_view[port_devctl_pkg::NO_SNOOP_BIT] = 1'b0;
    ctl_view[port_devctl_pkg::RDREQ_MSB:port_devctl_pkg::RDREQ_LSB] = port_devctl_pkg::RDREQ_FIXED;

    ctl_view[port_devctl_pkg::RSVD_BIT] = 1'b0;

    // data stands only in the cycle after the read; unmapped reads return zero
    // the status half of the word is not kept here and reads as zero
    rdata_nxt = 32'h0000_0000;
    if (sel_rd) begin
      rdata_nxt = {16'h0000, ctl_view};
    end
  end

  // outputs straight from flops
  // read data returns to zero after one cycle, so a master that samples
  // late sees zero rather than stale data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end


  // control outputs are plain wires from the field flops
  // no logic sits between flop and port, so consumers see clean levels
  assign corr_report_en     = err_en_r[0];
  assign nonfatal_report_en = err_en_r[1];
  assign fatal_report_en    = err_en_r[2];
  assign unsup_report_en    = err_en_r[3];
  assign max_payload        = payload_r;
  assign aux_power_en       = aux_r;
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, nrst, por_nrst, large_payload_strap, reg_wr, reg_rd, aux_power_en;
  logic        corr_report_en, nonfatal_report_en, fatal_report_en, unsup_report_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  max_payload, payload_cap;
  int          n_errors, check_count;
  port_device_control uut (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // outputs packed as aux, payload, enables
  function automatic logic [31:0] outs();
    return {24'h0, aux_power_en, max_payload, unsup_report_en, fatal_report_en, nonfatal_report_en, corr_report_en};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // p low also pulls power-on reset
  task automatic pulse(input logic p);
    @(posedge clk);
    nrst     <= 1'b0;
    por_nrst <= p;
    repeat (2) @(posedge clk);
    nrst     <= 1'b1;
    por_nrst <= 1'b1;
  endtask
  task automatic t_fields();
    rd(8'hC8, 32'h0);
    chk({29'h0, payload_cap}, 32'h1);
    wr(8'hC8, 32'hFFFF_FFFF);
    rd(8'hC8, 32'h0000_042F);
    chk(outs(), 32'h0000_009F);
    for (int i = 0; i < 4; i++) begin
      wr(8'hC8, 32'h1 << i);
      rd(8'hC8, 32'h1 << i);
    end
    $display("t_fields done");
  endtask
  // every code under both capabilities
  task automatic t_payload();
    for (int s = 0; s < 2; s++) begin
      large_payload_strap <= s[0];
      repeat (8) @(posedge clk);
      chk({29'h0, payload_cap}, s + 1);
      for (int c = 0; c < 8; c++) begin
        wr(8'hC8, c << 5);
        rd(8'hC8, (c > s + 1 ? s + 1 : c) << 5);
      end
    end
    $display("t_payload done");
  endtask
  task automatic t_sticky();
    wr(8'hC8, 32'h0000_0401);
    pulse(1'b1);
    rd(8'hC8, 32'h0000_0400);
    pulse(1'b0);
    rd(8'hC8, 32'h0);
    wr(8'hC4, 32'hFFFF_FFFF);
    rd(8'hC4, 32'h0);
    rd(8'hC8, 32'h0);
    $display("t_sticky done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {nrst, por_nrst, large_payload_strap, reg_wr, reg_rd} = 5'h0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    pulse(1'b0);
    t_fields();
    t_payload();
    t_sticky();
    report_and_stop();
  end
endmodule
bind port_device_control port_devctl_asserts chk_i (.*);
`default_nettype wire
